//--- hdl/wit_defs.svh
// Purpose: Offsets, field positions, reset values and divider masks of the
//          watchdog / interval timer.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef WIT_DEFS_SVH
`define WIT_DEFS_SVH

// ----------------------------------------------------------------------
// Map
// ----------------------------------------------------------------------
`define WIT_BASE_ADDR 32'hFFFF_F100
`define WIT_OFS_CTRL 5'h00
`define WIT_OFS_STAT 5'h04
`define WIT_OFS_CNT 5'h08
`define WIT_OFS_TIN 5'h10
`define WIT_OFS_TOUT 5'h14
`define WIT_ADDR_PAD 2'h0

// ----------------------------------------------------------------------
// Control fields and status flags
// ----------------------------------------------------------------------
`define WIT_CKS_HI 2
`define WIT_CKS_LO 0
`define WIT_BIT_RESET_KIND_SELECT 3
`define WIT_BIT_CHIP_RESET_ENABLE_BIT 4
`define WIT_BIT_RUN 5
`define WIT_BIT_MODE 6
`define WIT_BIT_IRQEN 7
`define WIT_FLAG_WD 0
`define WIT_FLAG_IT 1

// ----------------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------------
`define WIT_CTRL_RST 8'h00
`define WIT_CNT_RST 8'h00
`define WIT_STAT_RST 2'h0
`define WIT_STAT_PAD 6'h00
`define WIT_CNT_MAX 8'hFF
`define WIT_CNT_ONE 8'h01
`define WIT_BYTE_ZERO 8'h00
`define WIT_TOUT_VAL 8'h00

// ----------------------------------------------------------------------
// Prescaler: tick when the low bits of the divider are all ones
// ----------------------------------------------------------------------
`define WIT_PRE_ZERO 13'h0000
`define WIT_PRE_ONE 13'h0001
`define WIT_MASK_2 13'h0001
`define WIT_MASK_8 13'h0007
`define WIT_MASK_32 13'h001F
`define WIT_MASK_64 13'h003F
`define WIT_MASK_256 13'h00FF
`define WIT_MASK_512 13'h01FF
`define WIT_MASK_2048 13'h07FF
`define WIT_MASK_8192 13'h1FFF

`endif

//--- hdl/wit_pkg.sv
// Purpose: Types shared by the timer files.
// Assumes: Nothing.
// Notes:   Numbers live in wit_defs.svh.
package wit_pkg;
    typedef logic [7:0] wit_byte_t;
    typedef logic [2:0] wit_sel_t;
    typedef logic [12:0] wit_pre_t;
    typedef logic [1:0] wit_flags_t;
    // Bus port access state, one-hot
    typedef enum logic [1:0] {WIT_IDLE = 2'b01, WIT_HELD = 2'b10} wit_bus_st_t;
    typedef struct packed {wit_bus_st_t st; logic oe; wit_byte_t rdata;} wit_bus_q_t;
    typedef struct packed {wit_pre_t div; logic tick;} wit_pre_q_t;
    typedef struct packed {
        wit_byte_t ctrl;
        wit_byte_t cnt;
        wit_flags_t flags;
        logic irq;
        logic po;
        logic mn;
        logic wdo;
    } wit_core_q_t;
endpackage

//--- hdl/wit_prescaler.sv
// Purpose: Free-running divider giving one tick per selected period.
// Assumes: ce_i low freezes everything.
// Notes:   Tick is registered, one clock wide.
`timescale 1ns/1ns
`include "wit_defs.svh"
module wit_prescaler (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Divider choice and tick
    input wire wit_pkg::wit_sel_t sel_i,
    output logic tick_o
);
    import wit_pkg::*;

    wit_pre_q_t q_reg;
    wit_pre_q_t q_next;

    // Mask of divider bits that must all be one for a tick
    function automatic wit_pre_t wit_mask(input wit_sel_t s);
        case (s)
            3'h0: wit_mask = `WIT_MASK_2;
            3'h1: wit_mask = `WIT_MASK_8;
            3'h2: wit_mask = `WIT_MASK_32;
            3'h3: wit_mask = `WIT_MASK_64;
            3'h4: wit_mask = `WIT_MASK_256;
            3'h5: wit_mask = `WIT_MASK_512;
            3'h6: wit_mask = `WIT_MASK_2048;
            default: wit_mask = `WIT_MASK_8192;
        endcase
    endfunction

    // Divider runs freely so a select change takes effect within one period
    always_comb
    begin
        q_next = q_reg;
        if (ce_i)
        begin
            q_next.div = q_reg.div + `WIT_PRE_ONE;
            q_next.tick = (q_reg.div & wit_mask(sel_i)) == wit_mask(sel_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            q_reg <= '{div: `WIT_PRE_ZERO, tick: 1'b0};
        else
            q_reg <= q_next;
    end

    assign tick_o = q_reg.tick;
endmodule // wit_prescaler

//--- hdl/wit_bus_port.sv
// Purpose: Strobed peripheral bus slave: decode, write strobes, read data.
// Assumes: Bridge signals come from logic on the same clock.
// Notes:   One access per strobe high phase.
`timescale 1ns/1ns
`include "wit_defs.svh"
module wit_bus_port (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Bridge side
    input wire logic psel_i,
    input wire logic pstb_i,
    input wire logic pwrite_i,
    input wire logic [2:0] paddr_i,
    output logic [7:0] pdata_o,
    output logic pdata_oe_o,
    // Register side
    input wire wit_pkg::wit_byte_t ctrl_i,
    input wire wit_pkg::wit_flags_t stat_i,
    input wire wit_pkg::wit_byte_t cnt_i,
    output logic wr_ctrl_o,
    output logic wr_cnt_o,
    output logic rd_stat_o
);
    import wit_pkg::*;

    wit_bus_q_t q_reg;
    wit_bus_q_t q_next;
    logic take;

    function automatic logic wit_hit(input logic [2:0] a, input logic [4:0] ofs);
        wit_hit = {a, `WIT_ADDR_PAD} == ofs;
    endfunction

    // Access taken once, on the first clock that sees select and strobe
    assign take = ce_i && psel_i && pstb_i && q_reg.st == WIT_IDLE;
    assign wr_ctrl_o = take && pwrite_i && wit_hit(paddr_i, `WIT_OFS_CTRL);
    assign wr_cnt_o = take && pwrite_i && wit_hit(paddr_i, `WIT_OFS_CNT);
    assign rd_stat_o = take && !pwrite_i && wit_hit(paddr_i, `WIT_OFS_STAT);

    // Read data is captured before the flags clear; unmapped reads give zero
    always_comb
    begin
        q_next = q_reg;
        if (ce_i)
        begin
            q_next.oe = psel_i && pstb_i && !pwrite_i;
            case (q_reg.st)
                WIT_IDLE:
                    if (take)
                    begin
                        q_next.st = WIT_HELD;
                        if (wit_hit(paddr_i, `WIT_OFS_CTRL))
                            q_next.rdata = ctrl_i;
                        else if (wit_hit(paddr_i, `WIT_OFS_STAT))
                            q_next.rdata = {`WIT_STAT_PAD, stat_i};
                        else if (wit_hit(paddr_i, `WIT_OFS_CNT))
                            q_next.rdata = cnt_i;
                        else
                            q_next.rdata = `WIT_TOUT_VAL;
                    end
                WIT_HELD:
                    if (!pstb_i || !psel_i)
                        q_next.st = WIT_IDLE;
                default: q_next.st = WIT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            q_reg <= '{st: WIT_IDLE, oe: 1'b0, rdata: `WIT_BYTE_ZERO};
        else
            q_reg <= q_next;
    end

    assign pdata_o = q_reg.rdata;
    assign pdata_oe_o = q_reg.oe;
endmodule // wit_bus_port

//--- hdl/wit_timer.sv
// Purpose: 8-bit watchdog / interval timer with status flags and reset
//          requests to the power management unit.
// Assumes: 50 MHz clk_i; bridge signals synchronous to clk_i.
// Notes:   ce_i low freezes every flip-flop in the block.
`timescale 1ns/1ns
`include "wit_defs.svh"
module wit_timer (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Peripheral bus from the bridge
    input wire logic periph_sel_i,
    input wire logic periph_strobe_i,
    input wire logic periph_write_i,
    input wire logic [2:0] periph_addr_i,
    input wire logic [7:0] periph_data_i,
    output logic [7:0] periph_data_o,
    output logic periph_data_oe_o,
    // Interrupt and power management requests
    output logic timer_irq_o,
    output logic poweron_reset_request_o,
    output logic manual_reset_request_o,
    output logic watchdog_out_o
);
    import wit_pkg::*;

    // ------------------------------------------------------------------
    // State and internal nets
    // ------------------------------------------------------------------
    wit_core_q_t q_reg;
    wit_core_q_t q_next;
    logic tick;
    logic wr_ctrl;
    logic wr_cnt;
    logic rd_stat;
    logic ovf;
    logic set_wd;
    logic set_it;

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    // Divider feeding the counter, steered by the clock select field
    wit_prescaler u_pre (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .sel_i(q_reg.ctrl[`WIT_CKS_HI:`WIT_CKS_LO]),
        .tick_o(tick)
    );

    // Bus slave; the bridge decodes the fixed base into select
    wit_bus_port u_bus (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .psel_i(periph_sel_i),
        .pstb_i(periph_strobe_i),
        .pwrite_i(periph_write_i),
        .paddr_i(periph_addr_i),
        .pdata_o(periph_data_o),
        .pdata_oe_o(periph_data_oe_o),
        .ctrl_i(q_reg.ctrl),
        .stat_i(q_reg.flags),
        .cnt_i(q_reg.cnt),
        .wr_ctrl_o(wr_ctrl),
        .wr_cnt_o(wr_cnt),
        .rd_stat_o(rd_stat)
    );

    // ------------------------------------------------------------------
    // Counter and overflow
    // ------------------------------------------------------------------
    // A counter write wins over a tick so a kick can never be undone
    always_comb
    begin
        ovf = 1'b0;
        if (ce_i && !wr_cnt && q_reg.ctrl[`WIT_BIT_RUN] && tick)
            ovf = q_reg.cnt == `WIT_CNT_MAX;
    end

    // Mode at the wrap decides which flag is raised
    assign set_wd = ovf && q_reg.ctrl[`WIT_BIT_MODE];
    assign set_it = ovf && !q_reg.ctrl[`WIT_BIT_MODE];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Outputs are computed from next flags so they align with the status
    always_comb
    begin
        q_next = q_reg;
        if (ce_i)
        begin
            if (wr_ctrl)
                q_next.ctrl = periph_data_i;
            if (wr_cnt)
                q_next.cnt = periph_data_i;
            else if (q_reg.ctrl[`WIT_BIT_RUN] && tick)
                q_next.cnt = q_reg.cnt + `WIT_CNT_ONE;
            // Set beats the read clear so a wrap during the read is kept
            q_next.flags[`WIT_FLAG_WD] = (q_reg.flags[`WIT_FLAG_WD] && !rd_stat)
                || set_wd;
            q_next.flags[`WIT_FLAG_IT] = (q_reg.flags[`WIT_FLAG_IT] && !rd_stat)
                || set_it;
            q_next.irq = q_next.ctrl[`WIT_BIT_IRQEN] && (|q_next.flags);
            q_next.po = q_next.flags[`WIT_FLAG_WD] && q_next.ctrl[`WIT_BIT_CHIP_RESET_ENABLE_BIT]
                && !q_next.ctrl[`WIT_BIT_RESET_KIND_SELECT];
            q_next.mn = q_next.flags[`WIT_FLAG_WD] && q_next.ctrl[`WIT_BIT_CHIP_RESET_ENABLE_BIT]
                && q_next.ctrl[`WIT_BIT_RESET_KIND_SELECT];
            q_next.wdo = q_next.flags[`WIT_FLAG_WD];
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // The reset request stays high until a status read clears the watchdog flag or a control write drops it
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            q_reg.ctrl <= `WIT_CTRL_RST;
            q_reg.cnt <= `WIT_CNT_RST;
            q_reg.flags <= `WIT_STAT_RST;
            q_reg.irq <= 1'b0;
            q_reg.po <= 1'b0;
            q_reg.mn <= 1'b0;
            q_reg.wdo <= 1'b0;
        end
        else
            q_reg <= q_next;
    end

    // Outputs straight from flip-flops
    assign timer_irq_o = q_reg.irq;
    assign poweron_reset_request_o = q_reg.po;
    assign manual_reset_request_o = q_reg.mn;
    assign watchdog_out_o = q_reg.wdo;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // A counted wrap of the counter
    sequence s_wrap;
        ce_i && !wr_cnt && q_reg.ctrl[`WIT_BIT_RUN] && tick
            && q_reg.cnt == `WIT_CNT_MAX;
    endsequence

    // A status read that races with no wrap
    sequence s_clean_read;
        rd_stat && !ovf;
    endsequence

    property p_wd_flag;
        @(posedge clk_i) disable iff (srst_i)
        s_wrap ##0 q_reg.ctrl[`WIT_BIT_MODE] |=> q_reg.flags[`WIT_FLAG_WD] && watchdog_out_o;
    endproperty
    a_wd_flag: assert property (p_wd_flag) else $error("watchdog wrap lost");

    property p_it_flag;
        @(posedge clk_i) disable iff (srst_i)
        s_wrap ##0 !q_reg.ctrl[`WIT_BIT_MODE]
            |=> q_reg.flags[`WIT_FLAG_IT] && !$rose(q_reg.flags[`WIT_FLAG_WD]);
    endproperty
    a_it_flag: assert property (p_it_flag) else $error("interval wrap lost");

    property p_wrap_zero;
        @(posedge clk_i) disable iff (srst_i)
        s_wrap |=> q_reg.cnt == `WIT_CNT_RST;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("wrap not to zero");

    property p_count_up;
        @(posedge clk_i) disable iff (srst_i)
        ce_i && !wr_cnt && q_reg.ctrl[`WIT_BIT_RUN] && tick
            |=> q_reg.cnt == $past(q_reg.cnt) + `WIT_CNT_ONE;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step");

    property p_stopped;
        @(posedge clk_i) disable iff (srst_i)
        (!ce_i || !q_reg.ctrl[`WIT_BIT_RUN]) && !wr_cnt |=> $stable(q_reg.cnt);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

    property p_load;
        @(posedge clk_i) disable iff (srst_i)
        wr_cnt |=> q_reg.cnt == $past(periph_data_i);
    endproperty
    a_load: assert property (p_load) else $error("counter write lost");

    property p_read_clear;
        @(posedge clk_i) disable iff (srst_i)
        s_clean_read |=> q_reg.flags == `WIT_STAT_RST
            && periph_data_o == {`WIT_STAT_PAD, $past(q_reg.flags)};
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");

    property p_irq_gate;
        @(posedge clk_i) disable iff (srst_i)
        timer_irq_o == (q_reg.ctrl[`WIT_BIT_IRQEN] && (|q_reg.flags));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq mismatch");

    property p_rst_kind;
        @(posedge clk_i) disable iff (srst_i)
        (poweron_reset_request_o || manual_reset_request_o)
            |-> q_reg.ctrl[`WIT_BIT_CHIP_RESET_ENABLE_BIT] && q_reg.flags[`WIT_FLAG_WD]
            && (poweron_reset_request_o != q_reg.ctrl[`WIT_BIT_RESET_KIND_SELECT])
            && (manual_reset_request_o == q_reg.ctrl[`WIT_BIT_RESET_KIND_SELECT]);
    endproperty
    a_rst_kind: assert property (p_rst_kind) else $error("bad reset request");

    property p_po_raise;
        @(posedge clk_i) disable iff (srst_i)
        s_wrap ##0 q_reg.ctrl[`WIT_BIT_MODE] && q_reg.ctrl[`WIT_BIT_CHIP_RESET_ENABLE_BIT]
            && !q_reg.ctrl[`WIT_BIT_RESET_KIND_SELECT] && !wr_ctrl |=> poweron_reset_request_o;
    endproperty
    a_po_raise: assert property (p_po_raise) else $error("no power-on request");

    property p_reset_vals;
        @(posedge clk_i)
        srst_i |=> q_reg.cnt == `WIT_CNT_RST && q_reg.ctrl == `WIT_CTRL_RST
            && q_reg.flags == `WIT_STAT_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

    property p_interval_mode;
        @(posedge clk_i) disable iff (srst_i)
        s_wrap ##0 !q_reg.ctrl[`WIT_BIT_MODE] && q_reg.ctrl[`WIT_BIT_IRQEN] && !wr_ctrl
            |=> timer_irq_o && !poweron_reset_request_o ##0 !$rose(manual_reset_request_o);
    endproperty
    a_interval_mode: assert property (p_interval_mode) else $error("interval irq");
endmodule // wit_timer

//--- sim/wit_bridge_model.sv
// Purpose: Bus bridge model issuing strobed reads and writes to the timer.
// Assumes: Same clock as the timer; no wait states on this bus.
// Notes:   Released lines show the inverse of their last value.
`timescale 1ns/1ns
module wit_bridge_model (
    // Clock
    input wire logic clk_i,
    // Bridge outputs
    output logic sel_o,
    output logic stb_o,
    output logic write_o,
    output logic [2:0] addr_o,
    output logic [7:0] data_o,
    // Read return
    input wire logic [7:0] rdata_i,
    input wire logic rdata_oe_i
);
    // ------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------
    initial
    begin
        sel_o = 1'b0;
        stb_o = 1'b0;
        write_o = 1'b0;
        addr_o = 3'h7;
        data_o = 8'h00;
    end

    // One access per strobe; inverted release lines keep stale values from passing
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic oe);
        @(posedge clk_i);
        sel_o <= 1'b1;
        stb_o <= 1'b1;
        write_o <= wr;
        addr_o <= a;
        data_o <= d;
        @(posedge clk_i);
        sel_o <= 1'b0;
        stb_o <= 1'b0;
        write_o <= ~wr;
        addr_o <= ~a;
        data_o <= ~d;
        #1;
        q = rdata_i;
        oe = rdata_oe_i;
    endtask
endmodule // wit_bridge_model

//--- sim/watchdog_interval_timer_test.sv
// Purpose: Self-checking bench for the watchdog / interval timer.
// Assumes: Divide-by-2 prescale for overflow scenarios keeps the run short.
// Notes:   Clock enable is high except for the frozen-write check in t_stopped; the bridge model makes every access.
`timescale 1ns/1ns
module watchdog_interval_timer_test;
    import wit_pkg::*;
    logic clk_i;
    logic srst_i;
    logic ce_i;
    logic sel;
    logic stb;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic oe;
    logic irq;
    logic por;
    logic mnr;
    logic wdo;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;

    // ------------------------------------------------------------
    // Clock, reset, instances
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial
    begin
        srst_i = 1'b1;
        ce_i = 1'b1;
    end
    always @(posedge clk_i) cyc <= cyc + 1;

    wit_timer dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .periph_sel_i(sel),
        .periph_strobe_i(stb), .periph_write_i(wr), .periph_addr_i(addr),
        .periph_data_i(wdata), .periph_data_o(rdata), .periph_data_oe_o(oe),
        .timer_irq_o(irq), .poweron_reset_request_o(por),
        .manual_reset_request_o(mnr), .watchdog_out_o(wdo));
    wit_bridge_model bridge_u (.clk_i(clk_i), .sel_o(sel), .stb_o(stb), .write_o(wr),
        .addr_o(addr), .data_o(wdata), .rdata_i(rdata), .rdata_oe_i(oe));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wrr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic o;
        bridge_u.access(1'b1, a, d, q, o);
    endtask
    task automatic rdr(input logic [2:0] a, output logic [7:0] q);
        logic o;
        bridge_u.access(1'b0, a, 8'h00, q, o);
        check(o, 1'b1, "read enable");
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        rdr(a, q);
        check(q, exp, what);
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Bounded wait for an interrupt or watchdog output
    task automatic wait_out(input int lim);
        int n;
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        while (!(irq | wdo) && n < lim);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_map();
        logic [2:0] odd [6] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
        rd_chk(3'h0, 8'h00, "ctrl reset");
        rd_chk(3'h1, 8'h00, "status reset");
        rd_chk(3'h2, 8'h00, "count reset");
        check({irq, por, mnr, wdo}, 4'h0, "outputs reset");
        // Read-only, write-only and unmapped places all read zero
        foreach (odd[i])
        begin
            wrr(odd[i], 8'hFF);
            rd_chk(odd[i], 8'h00, "odd place");
        end
        rd_chk(3'h0, 8'h00, "ctrl untouched");
    endtask

    task automatic t_stopped();
        wrr(3'h0, 8'h1F);
        rd_chk(3'h0, 8'h1F, "ctrl rw");
        wrr(3'h2, 8'h5A);
        repeat (50) @(posedge clk_i);
        rd_chk(3'h2, 8'h5A, "stopped count");
        // Clock enable low: bus writes and every register are frozen
        @(posedge clk_i);
        ce_i <= 1'b0;
        wrr(3'h2, 8'h11);
        wrr(3'h0, 8'hA0);
        @(posedge clk_i);
        ce_i <= 1'b1;
        rd_chk(3'h2, 8'h5A, "frozen count");
        rd_chk(3'h0, 8'h1F, "frozen ctrl");
        wrr(3'h0, 8'h00);
    endtask

    task automatic t_prescale();
        int div [8] = '{2, 8, 32, 64, 256, 512, 2048, 8192};
        logic [7:0] q;
        // Window of 3 periods plus the access gives 3 or 4 ticks
        for (int c = 0; c < 8; c++)
        begin
            wrr(3'h0, 8'h20 | 8'(c));
            wrr(3'h2, 8'h00);
            repeat (3 * div[c]) @(posedge clk_i);
            rdr(3'h2, q);
            check(q >= 8'h03 && q <= 8'h04, 1'b1, "prescale ticks");
        end
        wrr(3'h0, 8'h00);
    endtask

    task automatic t_interval();
        int t1;
        logic [7:0] q;
        do_reset();
        wrr(3'h0, 8'hA0);
        wrr(3'h2, 8'hFD);
        wait_out(20);
        check(irq, 1'b1, "interval irq");
        check({por, mnr, wdo}, 3'h0, "no reset in interval");
        t1 = cyc;
        rd_chk(3'h1, 8'h02, "interval flag");
        rd_chk(3'h1, 8'h00, "flag cleared");
        check(irq, 1'b0, "irq cleared");
        wait_out(600);
        check(16'(cyc - t1), 16'd512, "overflow period");
        // Interrupt disabled: flag still set, request held low
        wrr(3'h0, 8'h20);
        rdr(3'h1, q);
        wrr(3'h2, 8'hFD);
        repeat (20) @(posedge clk_i);
        check(irq, 1'b0, "irq masked");
        rd_chk(3'h1, 8'h02, "masked flag");
        wrr(3'h0, 8'h00);
    endtask

    task automatic t_watchdog();
        logic [7:0] tab [4] = '{8'hE0, 8'hF0, 8'hF8, 8'h78};
        logic [7:0] v;
        foreach (tab[i])
        begin
            v = tab[i];
            do_reset();
            wrr(3'h0, v);
            wrr(3'h2, 8'hFD);
            wait_out(20);
            check(wdo, 1'b1, "watchdog out");
            check(irq, v[7], "watchdog irq");
            check(por | mnr, v[4], "chip reset enable");
            check(por, v[4] & ~v[3], "poweron request");
            check(mnr, v[4] & v[3], "manual request");
            rd_chk(3'h1, 8'h01, "watchdog flag");
        end
    endtask

    task automatic t_kick();
        do_reset();
        wrr(3'h0, 8'hE0);
        // Rewrites every ~300 cycles stay well inside the 512-cycle wrap
        repeat (6)
        begin
            wrr(3'h2, 8'h00);
            repeat (300) @(posedge clk_i);
        end
        check(wdo, 1'b0, "kicked watchdog");
        wrr(3'h0, 8'h00);
    endtask

    task automatic t_write_wins();
        logic [7:0] q;
        logic [7:0] q0;
        wrr(3'h0, 8'h20);
        // Loads five edges apart, so the divide-by-2 tick hits the load edge in one pass only
        for (int ph = 0; ph < 2; ph++)
        begin
            repeat (ph) @(posedge clk_i);
            wrr(3'h2, 8'h40);
            rdr(3'h2, q);
            check(q >= 8'h40 && q <= 8'h41, 1'b1, "write beats tick");
            if (ph == 1)
                check(q != q0, 1'b1, "tick phases differ");
            q0 = q;
        end
        wrr(3'h0, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Run and verdict
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        do_reset();
        t_reset_map();
        t_stopped();
        t_prescale();
        t_interval();
        t_watchdog();
        t_kick();
        t_write_wins();
        final_report();
    end

    // Expected run is about 36k cycles; cut a hang at 100k
    initial
    begin
        #2_000_000;
        num_errors++;
        final_report();
    end
endmodule // watchdog_interval_timer_test
